// [rtl/trc_pkg.sv]
// Package: constants, register map and carrier types of the read-out controller
package trc_pkg;
   localparam int LINK_W         = 20;
   localparam int HIT_SETS       = 16;
   localparam int HIT_W          = 48;
   localparam int BCN_W          = 12;
   localparam int DEPTH          = 128;
   localparam int AW             = 7;
   localparam int ROI_FIELDS     = 16;
   localparam int ROI_BCN_FIELDS = 12;
   localparam int PIN_W          = 43;

   localparam logic [7:0] DAQ_APPEND     = 8'h03;
   localparam logic [7:0] ROI_APPEND     = 8'h01;
   localparam logic [7:0] DAQ_MAX_SLICES = 8'h05;
   localparam logic [7:0] DIAG_MAX_SLICES = 8'h80;
   localparam logic [7:0] FIFO_FULL      = 8'h80;
   localparam logic [6:0] PIPE_LAST      = 7'h7F;

   localparam logic [7:0] RST_SLICES = 8'h01;
   localparam logic [7:0] RST_SRLEN  = 8'h50;
   localparam logic [6:0] RST_OFFSET = 7'h00;

   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_OFFSET  = 8'h04;
   localparam logic [7:0] ADDR_SRLEN   = 8'h08;
   localparam logic [7:0] ADDR_STATUS  = 8'h0C;
   localparam logic [7:0] ADDR_FIFO_LO = 8'h10;
   localparam logic [7:0] ADDR_FIFO_HI = 8'h14;
   localparam logic [7:0] ADDR_BCN     = 8'h18;

   localparam int CTRL_DIAG_BIT = 8;
   localparam int CTRL_ROI_BIT  = 9;
   localparam int CTRL_ART_BIT  = 10;
   localparam int STAT_ERR_BIT  = 0;

   typedef struct packed {
      logic             last;
      logic [BCN_W-1:0] crossing_number;
      logic [HIT_W-1:0] hits;
   } trc_entry_t;

   localparam int ENTRY_W = $bits(trc_entry_t);

   typedef struct packed {
      logic [7:0] slices;
      logic       diag;
      logic       region_of_interest;
      logic [6:0] offset;
      logic [7:0] sr_len;
   } trc_cfg_t;

   typedef enum logic [1:0] {
      SER_IDLE  = 2'b00,
      SER_SHIFT = 2'b01,
      SER_GAP   = 2'b10
   } trc_ser_t;

   // Effective slices per accept
   function automatic logic [7:0] trc_slices(input trc_cfg_t c);
      if (c.region_of_interest || c.slices == 8'h00) return 8'h01;
      if (!c.diag && c.slices > DAQ_MAX_SLICES) return DAQ_MAX_SLICES;
      if (c.slices > DIAG_MAX_SLICES) return DIAG_MAX_SLICES;
      return c.slices;
   endfunction : trc_slices
endpackage : trc_pkg

// [rtl/trc_sync.sv]
// Two-flop synchroniser for a group of pin inputs
module trc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_r <= '0;
         q_o    <= '0;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule : trc_sync

// [rtl/trc_mem.sv]
// Simple dual-port memory with registered read data
module trc_mem #(
   parameter int W     = 8,
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [W-1:0]  wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [W-1:0]  rdata_o
);
   logic [W-1:0] mem_r [DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_r[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= mem_r[raddr_i];
   end
endmodule : trc_mem

// [rtl/trc_readout.sv]
// Read-out controller: accept handling, pipelines, queue and link framer
// What this block does
// RULE_01: Accepts five ticks apart are taken; the queue holds slices pending.
// RULE_02: Slices per accept one to five on acquisition, one on ROI.
// RULE_03: Each source device's slice goes serially on its own link bit.
// RULE_04: External serial inputs are re-timed onto our clock before the link.
// RULE_05: After shift-length bits, all FIFOs load the next slice together.
// RULE_06: Frame signal stays high over all slice bits of one event.
// RULE_07: Hit results are pipelined and read at their own programmed offset.
// RULE_08: Crossing number is appended on acquisition and ROI streams.
// RULE_09: One parity bit per stream over slice and appended bits.
// RULE_10: After the external slice, output switches to internal shift data.
// RULE_11: External empty flags compared to internal queue; mismatch raises error.
// RULE_12: Diagnostic mode: full slice count, artificial accept, bus-readable queue.
// RULE_13: Pipeline and queue each hold 128 entries.
// RULE_14: 12-bit crossing counter, cleared by bunch reset, captured per accept.
// RULE_15: Acquisition link word is 20 bits, one per source device.
// RULE_16: 80 device bits, three appended: hits on D0..D15, crossing on D16..D19.
// RULE_17: Parity follows the preceding 83 bits of an acquisition slice.
// RULE_18: All slices of one accept carry the accept's crossing number.
// RULE_19: ROI stream uses 16 link bit positions only.
// RULE_20: ROI slice holds pass mask, flags and position code from devices.
// RULE_21: ROI mode has no hit pipeline; one crossing bit on D0..D11.
// RULE_22: Pipeline reset zeroes write address; read address returns to minus offset.
// RULE_23: Pipeline counter reset every 128 ticks, driven out to devices.
// RULE_24: Slices of one event shift out without gaps; a gap follows the event's last slice.
// RULE_25: Link output is retimed to the link's own clock edges.
// RULE_26: Mismatch latched in a status bit until software clears it.
// RULE_27: Slice count, hit offset and shift length are bus registers.
module trc_readout (
   input  wire logic                         clk_i,
   input  wire logic                         arst_n_i,
   input  wire logic                         psel_i,
   input  wire logic                         penable_i,
   input  wire logic                         pwrite_i,
   input  wire logic [7:0]                   paddr_i,
   input  wire logic [31:0]                  pwdata_i,
   output logic      [31:0]                  prdata_o,
   output logic                              pready_o,
   output logic                              pslverr_o,
   input  wire logic                         trigger_accept_i,
   input  wire logic                         bunch_counter_reset_i,
   input  wire logic [trc_pkg::HIT_W-1:0]    hit_counts_i,
   input  wire logic [trc_pkg::LINK_W-1:0]   ext_serial_i,
   input  wire logic [trc_pkg::LINK_W-1:0]   queue_empty_flag_i,
   input  wire logic                         link_clk_i,
   output logic                              pipeline_counter_reset_o,
   output logic                              ext_fetch_o,
   output logic                              ext_load_o,
   output logic                              ext_shift_o,
   output logic      [trc_pkg::LINK_W-1:0]   link_data_o,
   output logic                              link_frame_o,
   output logic                              mismatch_o
);
   import trc_pkg::*;

   logic [PIN_W-1:0]  pins_raw;
   logic [PIN_W-1:0]  pins_s;
   logic [LINK_W-1:0] ser_s;
   logic [LINK_W-1:0] ef_s;
   logic              bcr_s;
   logic              acc_s;
   logic              lclk_s;
   logic              acc_d_r;
   logic              lclk_d_r;
   logic              acc_ev;
   logic              lt;

   trc_cfg_t          cfg_r;
   logic              art_r;
   logic              err_r;
   logic              mis_r;
   logic [BCN_W-1:0]  bcn_r;
   logic [BCN_W-1:0]  bcn_hold_r;
   logic [6:0]        pwa_r;
   logic [6:0]        pra;
   logic              pcr_r;
   logic [HIT_W-1:0]  pipe_rdata;

   logic [7:0]        remain_r;
   logic [7:0]        nslices;
   logic              busy;
   logic              start;
   logic              push;
   logic              push_ok;
   trc_entry_t        push_e;
   logic              fetch_r;

   logic [6:0]        wp_r;
   logic [6:0]        rp_r;
   logic [7:0]        cnt_r;
   logic              head_ok_r;
   logic              fifo_empty;
   trc_entry_t        fifo_head;
   logic              pop;
   logic              bus_pop;

   trc_ser_t          ser_st_r;
   logic [8:0]        bit_cnt_r;
   logic [8:0]        end_cnt;
   logic [7:0]        app_n;
   logic [1:0]        app_idx;
   logic              ext_phase;
   trc_entry_t        cur_r;
   logic [LINK_W-1:0] par_r;
   logic [LINK_W-1:0] emit_w;
   logic [LINK_W-1:0] field_en;
   logic              ser_go;
   logic              ser_load;
   logic [LINK_W-1:0] link_data_r;
   logic              link_frame_r;
   logic              ext_load_r;
   logic              ext_shift_r;

   logic              apb_setup;
   logic              apb_wr;
   logic              apb_rd;
   logic [31:0]       rdata_r;
   logic              slverr_r;

   // Pins pass two flops before use
   assign pins_raw = {link_clk_i, trigger_accept_i, bunch_counter_reset_i,
                      queue_empty_flag_i, ext_serial_i};

   trc_sync #(.W(PIN_W)) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .d_i      (pins_raw),
      .q_o      (pins_s)
   );

   assign ser_s  = pins_s[LINK_W-1:0]; // [RULE_04]
   assign ef_s   = pins_s[2*LINK_W-1:LINK_W];
   assign bcr_s  = pins_s[2*LINK_W];
   assign acc_s  = pins_s[2*LINK_W+1];
   assign lclk_s = pins_s[2*LINK_W+2];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         acc_d_r  <= 1'b0;
         lclk_d_r <= 1'b0;
      end else begin
         acc_d_r  <= acc_s;
         lclk_d_r <= lclk_s;
      end
   end

   assign acc_ev = acc_s & ~acc_d_r;
   assign lt     = lclk_s & ~lclk_d_r; // [RULE_25]

   // Crossing counter
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bcn_r <= '0;
      end else if (bcr_s) begin
         bcn_r <= '0; // [RULE_14]
      end else begin
         bcn_r <= bcn_r + 12'h001;
      end
   end

   // Pipeline address counter and its periodic reset
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pwa_r <= '0;
         pcr_r <= 1'b0;
      end else begin
         pcr_r <= (pwa_r == PIPE_LAST); // [RULE_23]
         if (pwa_r == PIPE_LAST) begin
            pwa_r <= '0; // [RULE_22]
         end else begin
            pwa_r <= pwa_r + 7'h01;
         end
      end
   end

   assign pra = pwa_r - cfg_r.offset; // [RULE_07] [RULE_22]

   trc_mem #(.W(HIT_W), .DEPTH(DEPTH), .AW(AW)) u_pipe ( // [RULE_13]
      .clk_i   (clk_i),
      .we_i    (1'b1),
      .waddr_i (pwa_r),
      .wdata_i (hit_counts_i),
      .raddr_i (pra),
      .rdata_o (pipe_rdata)
   );

   // Slice fetch per accept
   assign nslices = trc_slices(cfg_r); // [RULE_02] [RULE_12]
   assign busy    = (remain_r != 8'h00);
   assign start   = ((acc_ev & ~cfg_r.diag) | art_r) & ~busy; // [RULE_12]
   assign push    = start | busy;

   always_comb begin
      push_e.last = start ? (nslices == 8'h01) : (remain_r == 8'h01);
      push_e.crossing_number  = start ? bcn_r : bcn_hold_r; // [RULE_18]
      push_e.hits = cfg_r.region_of_interest ? '0 : pipe_rdata; // [RULE_21]
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         remain_r   <= '0;
         bcn_hold_r <= '0;
         fetch_r    <= 1'b0;
      end else begin
         fetch_r <= push;
         if (start) begin
            remain_r   <= nslices - 8'h01;
            bcn_hold_r <= bcn_r; // [RULE_14]
         end else if (busy) begin
            remain_r <= remain_r - 8'h01;
         end
      end
   end

   // Internal queue of slices
   assign push_ok    = push & (cnt_r != FIFO_FULL); // [RULE_01]
   assign fifo_empty = (cnt_r == 8'h00);
   assign pop        = (ser_load | bus_pop) & head_ok_r;

   trc_mem #(.W(ENTRY_W), .DEPTH(DEPTH), .AW(AW)) u_queue ( // [RULE_13]
      .clk_i   (clk_i),
      .we_i    (push_ok),
      .waddr_i (wp_r),
      .wdata_i (push_e),
      .raddr_i (rp_r),
      .rdata_o (fifo_head)
   );

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp_r      <= '0;
         rp_r      <= '0;
         cnt_r     <= '0;
         head_ok_r <= 1'b0;
      end else begin
         if (push_ok) begin
            wp_r <= wp_r + 7'h01;
         end
         if (pop) begin
            rp_r <= rp_r + 7'h01;
         end
         if (push_ok && !pop) begin
            cnt_r <= cnt_r + 8'h01;
         end else if (pop && !push_ok) begin
            cnt_r <= cnt_r - 8'h01;
         end
         head_ok_r <= ~fifo_empty & ~pop;
      end
   end

   // Empty flag comparison
   assign field_en = cfg_r.region_of_interest ? {{(LINK_W-ROI_FIELDS){1'b0}},
                                  {ROI_FIELDS{1'b1}}}
                               : {LINK_W{1'b1}}; // [RULE_19] [RULE_15]

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mis_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         mis_r <= |((ef_s ^ {LINK_W{fifo_empty}}) & field_en); // [RULE_11]
         if (mis_r) begin
            err_r <= 1'b1; // [RULE_26]
         end else if (apb_wr && paddr_i == ADDR_STATUS
                      && pwdata_i[STAT_ERR_BIT]) begin
            err_r <= 1'b0;
         end
      end
   end

   // Appended bit for one field
   function automatic logic append_bit(input trc_entry_t e, input logic region_of_interest,
                                       input int f, input logic [1:0] j);
      int idx;
      idx = 0;
      if (region_of_interest) begin
         return (f < ROI_BCN_FIELDS) ? e.crossing_number[f] : 1'b0; // [RULE_21]
      end
      if (f < HIT_SETS) begin
         idx = 3 * f + int'(j);
         return e.hits[idx]; // [RULE_16]
      end
      idx = 3 * (f - HIT_SETS) + int'(j);
      return e.crossing_number[idx]; // [RULE_08]
   endfunction : append_bit

   // Link word for the current bit position
   assign app_n     = cfg_r.region_of_interest ? ROI_APPEND : DAQ_APPEND;
   assign end_cnt   = {1'b0, cfg_r.sr_len} + {1'b0, app_n}; // [RULE_17]
   assign ext_phase = (bit_cnt_r < {1'b0, cfg_r.sr_len}); // [RULE_05]
   assign app_idx   = 2'(bit_cnt_r - {1'b0, cfg_r.sr_len});

   always_comb begin
      emit_w = '0;
      for (int f = 0; f < LINK_W; f++) begin
         if (ext_phase) begin
            emit_w[f] = ser_s[f] & field_en[f]; // [RULE_03] [RULE_20]
         end else if (bit_cnt_r < end_cnt) begin
            emit_w[f] = append_bit(cur_r, cfg_r.region_of_interest, f, app_idx)
                        & field_en[f]; // [RULE_10]
         end else begin
            emit_w[f] = par_r[f] & field_en[f]; // [RULE_09]
         end
      end
   end

   assign ser_go   = head_ok_r & ~cfg_r.diag;
   assign ser_load = lt & ser_go
                     & ((ser_st_r == SER_IDLE)
                        | ((ser_st_r == SER_SHIFT) & ~cur_r.last
                           & (bit_cnt_r >= end_cnt))); // [RULE_24]

   // Link framer on link clock ticks
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ser_st_r     <= SER_IDLE;
         bit_cnt_r    <= '0;
         cur_r        <= '0;
         par_r        <= '0;
         link_data_r  <= '0;
         link_frame_r <= 1'b0;
         ext_load_r   <= 1'b0;
         ext_shift_r  <= 1'b0;
      end else begin
         ext_load_r  <= 1'b0;
         ext_shift_r <= 1'b0;
         if (lt) begin
            case (ser_st_r)
               SER_IDLE: begin
                  link_frame_r <= 1'b0;
                  link_data_r  <= '0;
                  if (ser_load) begin
                     cur_r      <= fifo_head;
                     par_r      <= '0;
                     bit_cnt_r  <= '0;
                     ext_load_r <= 1'b1; // [RULE_05]
                     ser_st_r   <= SER_SHIFT;
                  end
               end
               SER_SHIFT: begin
                  link_frame_r <= 1'b1; // [RULE_06]
                  if (bit_cnt_r < end_cnt) begin
                     link_data_r <= emit_w;
                     par_r       <= par_r ^ emit_w; // [RULE_09]
                     ext_shift_r <= ext_phase;
                     bit_cnt_r   <= bit_cnt_r + 9'h001;
                  end else begin
                     link_data_r <= (bit_cnt_r == end_cnt) ? emit_w : '0;
                     if (cur_r.last) begin
                        ser_st_r <= SER_GAP;
                     end else if (ser_load) begin
                        cur_r      <= fifo_head;
                        par_r      <= '0;
                        bit_cnt_r  <= '0;
                        ext_load_r <= 1'b1; // [RULE_24]
                     end else begin
                        bit_cnt_r <= end_cnt + 9'h001;
                     end
                  end
               end
               SER_GAP: begin
                  link_frame_r <= 1'b0;
                  link_data_r  <= '0;
                  ser_st_r     <= SER_IDLE;
               end
               default: begin
                  ser_st_r <= SER_IDLE;
               end
            endcase
         end
      end
   end

   // APB slave, zero wait states
   assign apb_setup = psel_i & ~penable_i;
   assign apb_wr    = psel_i & penable_i & pwrite_i;
   assign apb_rd    = psel_i & penable_i & ~pwrite_i;
   assign bus_pop   = apb_rd & (paddr_i == ADDR_FIFO_HI) & cfg_r.diag; // [RULE_12]

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_r.slices <= RST_SLICES;
         cfg_r.diag   <= 1'b0;
         cfg_r.region_of_interest    <= 1'b0;
         cfg_r.offset <= RST_OFFSET;
         cfg_r.sr_len <= RST_SRLEN;
         art_r        <= 1'b0;
      end else begin
         art_r <= 1'b0;
         if (apb_wr) begin
            case (paddr_i)
               ADDR_CTRL: begin
                  cfg_r.slices <= pwdata_i[7:0]; // [RULE_27]
                  cfg_r.diag   <= pwdata_i[CTRL_DIAG_BIT];
                  cfg_r.region_of_interest    <= pwdata_i[CTRL_ROI_BIT];
                  art_r        <= pwdata_i[CTRL_ART_BIT]; // [RULE_12]
               end
               ADDR_OFFSET: begin
                  cfg_r.offset <= pwdata_i[6:0]; // [RULE_27]
               end
               ADDR_SRLEN: begin
                  cfg_r.sr_len <= pwdata_i[7:0]; // [RULE_27]
               end
               default: begin
                  art_r <= 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r  <= '0;
         slverr_r <= 1'b0;
      end else if (apb_setup) begin
         slverr_r <= 1'b0;
         case (paddr_i)
            ADDR_CTRL:    rdata_r <= {22'h000000, cfg_r.region_of_interest, cfg_r.diag,
                                      cfg_r.slices};
            ADDR_OFFSET:  rdata_r <= {25'h0000000, cfg_r.offset};
            ADDR_SRLEN:   rdata_r <= {24'h000000, cfg_r.sr_len};
            ADDR_STATUS:  rdata_r <= {16'h0000, cnt_r, 5'h00, busy,
                                      fifo_empty, err_r};
            ADDR_FIFO_LO: rdata_r <= head_ok_r ? fifo_head.hits[31:0]
                                               : 32'h00000000;
            ADDR_FIFO_HI: rdata_r <= head_ok_r ? {3'h0, fifo_head.last,
                                      fifo_head.crossing_number, fifo_head.hits[47:32]}
                                               : 32'h00000000;
            ADDR_BCN:     rdata_r <= {20'h00000, bcn_r};
            default: begin
               rdata_r  <= '0;
               slverr_r <= 1'b1;
            end
         endcase
      end
   end

   assign prdata_o  = rdata_r;
   assign pready_o  = 1'b1;
   assign pslverr_o = slverr_r & psel_i & penable_i;

   assign pipeline_counter_reset_o = pcr_r; // [RULE_23]
   assign ext_fetch_o              = fetch_r;
   assign ext_load_o               = ext_load_r;
   assign ext_shift_o              = ext_shift_r;
   assign link_data_o              = link_data_r;
   assign link_frame_o             = link_frame_r;
   assign mismatch_o               = mis_r; // [RULE_11]
endmodule : trc_readout

// [verification/trc_readout_asserts.sv]
// Checker: port assertions of the read-out controller
module trc_readout_asserts (
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        trigger_accept_i,
   input wire logic        pipeline_counter_reset_o,
   input wire logic        ext_fetch_o,
   input wire logic        ext_load_o,
   input wire logic        ext_shift_o,
   input wire logic        link_frame_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_fetch; ##3 ext_fetch_o; endsequence
   sequence s_period; !pipeline_counter_reset_o ##127 pipeline_counter_reset_o; endsequence
   property p_ready; pready_o; endproperty
   property p_slverr; pslverr_o |-> psel_i && penable_i && prdata_o == 32'h0; endproperty
   property p_fetch; $rose(trigger_accept_i) |-> s_fetch; endproperty
   property p_pcr; $rose(pipeline_counter_reset_o) |=> s_period; endproperty
   property p_load; ext_load_o |=> !ext_load_o [*8]; endproperty
   property p_shift; ext_shift_o |=> !ext_shift_o [*8]; endproperty
   property p_frame; $rose(link_frame_o) |-> $past(ext_load_o, 16); endproperty
   property p_inframe; ext_shift_o |-> ##[0:17] link_frame_o; endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   a_slverr: assert property (p_slverr) else $error("bad error");
   a_fetch: assert property (p_fetch) else $error("no fetch");
   a_pcr: assert property (p_pcr) else $error("reset period");
   a_load: assert property (p_load) else $error("load pulse");
   a_shift: assert property (p_shift) else $error("shift pulse");
   a_frame: assert property (p_frame) else $error("frame start");
   a_inframe: assert property (p_inframe) else $error("no frame");
endmodule : trc_readout_asserts

bind trc_readout trc_readout_asserts u_chk (.*);

// [verification/trc_dev_model.sv]
// Partner model: device shift registers, empty flags, link oscillator
module trc_dev_model (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        fetch_i,
   input  wire logic        load_i,
   input  wire logic        shift_i,
   input  wire logic        bad_i,
   output logic             lclk_o,
   output logic [19:0]      ser_o,
   output logic [19:0]      empty_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   initial begin
      lclk_o = 1'b0;
      #23;
      forever #80 lclk_o = ~lclk_o;
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt   <= 0;
         ser_o <= 20'h5A3C1;
      end else begin
         cnt <= cnt + int'(fetch_i) - int'(load_i);
         if (shift_i || load_i)
            ser_o <= {ser_o[18:0], ~ser_o[19] ^ ser_o[7]};
      end
   end
   assign empty_o = {20{cnt == 0}} ^ {19'h0, bad_i};
endmodule : trc_dev_model

// [verification/trc_readout_tb.sv]
// Testbench of the read-out controller
module trc_readout_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import trc_pkg::*;
   localparam int L = 8;
   logic        clk_i = 1'b0, arst_n_i = 1'b0, bad = 1'b0;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic        trigger_accept_i = 1'b0, bunch_counter_reset_i = 1'b1;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, seed = 32'h3D, prdata_o;
   logic [47:0] hit_counts_i = 48'h0;
   logic        pready_o, pslverr_o, link_clk_i, pipeline_counter_reset_o;
   logic        ext_fetch_o, ext_load_o, ext_shift_o, link_frame_o, mismatch_o;
   logic [19:0] ext_serial_i, queue_empty_flag_i, link_data_o, ex;
   logic [19:0] par = 20'h0;
   logic [63:0] e, w, rq[$];
   int          error_cnt = 0, comparisons = 0, ticks = 0, k, fq[$];

   trc_readout dut (.*);
   trc_dev_model u_dev (.clk_i, .arst_n_i, .fetch_i(ext_fetch_o),
      .load_i(ext_load_o), .shift_i(ext_shift_o), .bad_i(bad),
      .lclk_o(link_clk_i), .ser_o(ext_serial_i),
      .empty_o(queue_empty_flag_i));

   always #5 clk_i = ~clk_i;

   function automatic logic [31:0] xs;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic end_sim;
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         error_cnt++;
         $display("BAD t=%0t exp=%h got=%h", $time, x, g);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      if (pready_o !== 1'b1) begin
         error_cnt++;
         end_sim;
      end
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
      rq.push_back({d & m, m});
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic acc(input int n);
      @(posedge clk_i);
      trigger_accept_i <= 1'b1;
      fq.push_back(n * (L + 4));
      @(posedge clk_i);
      trigger_accept_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : acc

   always @(posedge clk_i) begin
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
         e = rq.pop_front();
         chk(e[63:32], prdata_o & e[31:0]);
         chk({31'h0, paddr_i > ADDR_BCN}, {31'h0, pslverr_o});
      end
   end

   always @(negedge link_clk_i) begin
      if (link_frame_o === 1'b1) begin
         k = ticks % (L + 4);
         if (k >= L && k < L + 3) begin
            ex = 20'h0;
            for (int f = 0; f < 16; f++)
               ex[f] = hit_counts_i[3*f+k-L];
            chk({12'h0, ex}, {12'h0, link_data_o});
         end
         par ^= link_data_o;
         ticks++;
      end else if (ticks != 0) begin
         chk(32'h0, {12'h0, par});
         chk(32'(fq.pop_front()), 32'(ticks));
         ticks = 0;
         par = 20'h0;
      end
   end

   initial begin
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'b1;
      w = {xs(), xs()};
      hit_counts_i <= w[47:0];
      repeat (130) @(posedge clk_i);
      rd(ADDR_CTRL, {24'h0, RST_SLICES}, 32'h7FF);
      rd(ADDR_OFFSET, {25'h0, RST_OFFSET}, 32'h7F);
      rd(ADDR_SRLEN, {24'h0, RST_SRLEN}, 32'hFF);
      rd(8'h1C, 32'h0, 32'hFFFFFFFF);
      rd(ADDR_BCN, 32'h0, 32'hFFF);
      apb(1'b1, ADDR_SRLEN, 32'(L));
      for (int s = 1; s < 10; s += 8) begin
         apb(1'b1, ADDR_CTRL, 32'(s));
         repeat (2) acc((s > 5) ? 5 : s);
         for (int i = 0; i < 20000 && fq.size() > 0; i++)
            @(posedge clk_i);
         if (fq.size() > 0) begin
            error_cnt++;
            end_sim;
         end
      end
      apb(1'b1, ADDR_STATUS, 32'h1);
      bad <= 1'b1;
      repeat (8) @(posedge clk_i);
      rd(ADDR_STATUS, 32'h1, 32'h1);
      bad <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(ADDR_STATUS, 32'h1, 32'h1);
      apb(1'b1, ADDR_STATUS, 32'h1);
      rd(ADDR_STATUS, 32'h0, 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h103);
      apb(1'b1, ADDR_CTRL, 32'h503);
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 3; i++) begin
         rd(ADDR_FIFO_LO, w[31:0], 32'hFFFFFFFF);
         e = {32'h0, 3'h0, 1'(i == 2), 12'h0, w[47:32]};
         rd(ADDR_FIFO_HI, e[31:0], 32'hFFFFFFFF);
      end
      rd(ADDR_FIFO_HI, 32'h0, 32'hFFFFFFFF);
      end_sim;
   end
endmodule : trc_readout_tb
